// ### tb_tsc_top.sv
// testbench: register map, sequence timing and gpio interrupt of the touch sequencer
`timescale 1ns/1ps
module tb_tsc_top;
	import tsc_pkg::*;
	localparam logic [15:0] ID = 16'h3c5e; // arbitrary value
	logic mclk_i = 1'b0;
	logic rst_b_i;
	logic [3:0] addr;
	logic [15:0] wdata;
	logic wr;
	logic rd;
	logic [15:0] rdata;
	logic [11:0] adc_data;
	logic [2:0] chan;
	logic samp;
	logic conv;
	logic busy;
	logic gpio_i;
	logic gpio_o;
	logic gpio_oe;
	logic irq_n;
	int fail_count = 0;
	int n_checks = 0;
	int seed = 45;
	int n;
	logic [15:0] mdl [0:15];
	logic [15:0] v;
	initial forever #20 mclk_i = ~mclk_i;
	tsc_host host (.mclk_i(mclk_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
		.reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));
	tsc_top #(.SETTLE2_CYC(4), .SETTLE3_CYC(8), .GAP_STEP(3), .PART_ID(ID)) dut (
		.mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .adc_data_i(adc_data),
		.adc_chan_o(chan), .adc_sample_o(samp), .adc_convert_o(conv), .seq_busy_o(busy),
		.gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe_o(gpio_oe), .limit_irq_n_o(irq_n));
	//////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// two clocks of slack each way for the registered start and end
	task automatic chk_time(input int got, input int exp);
		n_checks++;
		if (got < exp - 2 || got > exp + 2)
		begin
			fail_count++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [3:0] a);
		host.rd(a, v);
		chk(v, mdl[a]);
	endtask
	task automatic wait4();
		repeat (4) @(posedge mclk_i);
		#1;
	endtask
	task automatic run(input logic [15:0] ca, input int eb, input int es,
		input logic [11:0] d, input logic [3:0] ra);
		int nb;
		int ns;
		int k;
		logic p;
		logic [2:0] lc;
		nb = 0;
		ns = 0;
		k = 0;
		p = 1'b0;
		lc = 3'b000;
		@(posedge mclk_i);
		adc_data <= d;
		host.wr(4'h1, ca);
		#1;
		while (busy !== 1'b1 && k < 20)
		begin
			@(posedge mclk_i);
			#1;
			k++;
		end
		while (busy === 1'b1 && nb < 40000)
		begin
			@(posedge mclk_i);
			#1;
			nb++;
			if (samp === 1'b1 && p !== 1'b1)
			begin
				ns++;
				lc = chan;
			end
			p = samp;
		end
		if (k >= 20 || nb >= 40000)
		begin
			fail_count++;
			complete_run();
		end
		else
		begin
			chk_time(nb, eb);
			chk(16'(ns), 16'(es));
			chk(16'(lc), (ra == 4'hd) ? 16'h0001 : 16'(4'hf - ra));
			host.rd(ra, v);
			chk(v, {4'h0, d});
		end
	endtask
	//////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (100000) @(posedge mclk_i);
		fail_count++;
		complete_run();
	end
	initial
	begin
		rst_b_i = 1'b0;
		gpio_i = 1'b0;
		adc_data = 12'h000;
		for (int i = 0; i < 16; i++)
			mdl[i] = 16'h0000;
		mdl[2] = CTRL_B_RST;
		mdl[14] = ID;
		repeat (12) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		for (int i = 0; i < 16; i++)
			rchk(i[3:0]);
		for (int i = 0; i < 14; i++)
			if (i == 0 || i > 3)
			begin
				v = 16'($random(seed));
				host.wr(i[3:0], v);
				if (i < 8)
					mdl[i] = v;
				rchk(i[3:0]);
			end
		host.wr(4'h3, 16'h1f3f);
		host.rd(4'h3, v);
		chk(v, 16'h1f3f);
		host.wr(4'h3, 16'h0001);
		for (int m = 0; m < 4; m++)
		begin
			host.wr(4'h2, 16'h4000 | 16'(m << 5));
			n = (m == 0) ? 1 : (2 << m);
			run(16'h0900, 200 + n * (288 + ((m > 0) ? 50 : 0)), n,
				12'($random(seed)), 4'h8);
		end
		host.wr(4'h2, 16'h4000);
		host.wr(4'h3, 16'h0003);
		run(16'h0901, 879, 2, 12'($random(seed)), 4'h9);
		host.wr(4'h4, 16'h0100);
		host.wr(4'h5, 16'h0000);
		host.wr(4'h3, 16'h0010);
		run(16'h09ff, 1253, 1, 12'h2a5, 4'hc);
		host.rd(4'h3, v);
		chk(v, 16'h2010);
		run(16'h1400, 788, 1, 12'($random(seed)), 4'hd);
		host.wr(4'h2, 16'h7400);
		wait4();
		chk({14'h0, gpio_oe, gpio_o}, 16'h0003);
		host.wr(4'h2, 16'h7000);
		wait4();
		chk({14'h0, gpio_oe, gpio_o}, 16'h0002);
		host.wr(4'h2, 16'h5400);
		wait4();
		chk(16'(gpio_oe), 16'h0000);
		host.wr(4'h1, 16'h8000);
		host.wr(4'h3, 16'h2000);
		host.wr(4'h2, 16'h6c00);
		@(posedge mclk_i);
		gpio_i <= 1'b1;
		wait4();
		chk(16'(irq_n), 16'h0000);
		host.wr(4'h0, 16'h0000);
		repeat (20) @(posedge mclk_i);
		#1;
		chk(16'(irq_n), 16'h0000);
		@(posedge mclk_i);
		gpio_i <= 1'b0;
		wait4();
		chk(16'(irq_n), 16'h0001);
		host.wr(4'h2, 16'h7400);
		@(posedge mclk_i);
		gpio_i <= 1'b1;
		wait4();
		chk(16'(irq_n), 16'h0001);
		host.wr(4'h3, 16'h1000);
		host.wr(4'h2, 16'h6c00);
		@(posedge mclk_i);
		gpio_i <= 1'b1;
		wait4();
		chk(16'(irq_n), 16'h0001);
		complete_run();
	end
endmodule
bind tsc_top tsc_chk #(.PART_ID(PART_ID)) u_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
	.reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.adc_sample_o(adc_sample_o), .adc_convert_o(adc_convert_o), .seq_busy_o(seq_busy_o));

// ### tsc_chk.sv
// checker: port timing and readback relations of the touch sequencer
`timescale 1ns/1ps
module tsc_chk
	import tsc_pkg::*;
#(
	parameter logic [15:0] PART_ID = 16'h0000
)
(
	input wire logic mclk_i, // clock
	input wire logic rst_b_i, // reset, active low
	input wire logic [3:0] reg_addr_i, // address
	input wire logic reg_rd_i, // read strobe
	input wire logic [15:0] reg_rdata_o, // read data
	input wire logic adc_sample_o, // acquisition window
	input wire logic adc_convert_o, // conversion window
	input wire logic seq_busy_o // sequence busy
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_b_i);
	logic [9:0] s_cnt_q;
	logic [9:0] c_cnt_q;
	//////////////////////////////////////////////////////////////////////
	// window lengths, cleared in reset so a stale count never leaks out
	always_ff @(posedge mclk_i)
	begin
		s_cnt_q <= (rst_b_i && adc_sample_o) ? s_cnt_q + 10'h001 : 10'h000;
	end
	always_ff @(posedge mclk_i)
	begin
		c_cnt_q <= (rst_b_i && adc_convert_o) ? c_cnt_q + 10'h001 : 10'h000;
	end
	//////////////////////////////////////////////////////////////////////
	a_no_overlap: assert property (!(adc_sample_o && adc_convert_o))
		else $error("sample and convert windows overlap");
	a_conv_after: assert property ($rose(adc_convert_o) |-> $past(adc_sample_o))
		else $error("conversion not preceded by acquisition");
	a_acq_len: assert property ($fell(adc_sample_o) |->
		s_cnt_q inside {10'h032, 10'h064, 10'h0c8, 10'h190})
		else $error("acquisition window length wrong");
	a_conv_len: assert property ($fell(adc_convert_o) |-> c_cnt_q == 10'h0bc)
		else $error("conversion window length wrong");
	a_busy_cover: assert property ((adc_sample_o || adc_convert_o) |-> seq_busy_o)
		else $error("phase active outside busy");
	a_id_read: assert property (reg_rd_i && reg_addr_i == 4'he |=> reg_rdata_o == PART_ID)
		else $error("identity read wrong");
	a_unmap_read: assert property (reg_rd_i && reg_addr_i == 4'hf |=> reg_rdata_o == 16'h0000)
		else $error("unmapped read not zero");
	a_res_width: assert property (reg_rd_i && reg_addr_i inside {[4'h8:4'hd]}
		|=> reg_rdata_o[15:12] == 4'h0)
		else $error("result upper bits set");
endmodule

// ### tsc_host.sv
// host model: drives the register strobe port as a host processor would
`timescale 1ns/1ps
module tsc_host
(
	input wire logic mclk_i, // clock
	input wire logic [15:0] reg_rdata_i, // read data from device
	output logic [3:0] reg_addr_o, // address
	output logic [15:0] reg_wdata_o, // write data
	output logic reg_wr_o, // write strobe
	output logic reg_rd_o // read strobe
);
	initial
	begin
		reg_addr_o = 4'h0;
		reg_wdata_o = 16'h0000;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
	end
	// idle bus shows inverted values so a late sample is caught
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		if (a != 4'hf)
		begin
			reg_addr_o <= a;
			reg_wdata_o <= d;
			reg_wr_o <= 1'b1;
		end
		@(posedge mclk_i);
		reg_wr_o <= 1'b0;
		reg_addr_o <= ~a;
		reg_wdata_o <= ~d;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge mclk_i);
		reg_addr_o <= a;
		reg_rd_o <= 1'b1;
		@(posedge mclk_i);
		reg_rd_o <= 1'b0;
		reg_addr_o <= ~a;
		#1;
		d = reg_rdata_i;
	endtask
endmodule

// ### tsc_pkg.sv
// package: register map, field layout, reset values and timing counts of the touch sequencer
package tsc_pkg;

	localparam int MCLK_HZ = 25_000_000;
	localparam int CNT_W = 24;

	// converts a time in ns to clock cycles, rounded up, at least one
	function automatic int ns_to_cyc_up(input int ns);
		int c;
		c = (ns * (MCLK_HZ / 1_000_000) + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction

	// register offsets
	localparam logic [3:0] ADDR_SPARE = 4'h0;
	localparam logic [3:0] ADDR_CTRL_A = 4'h1;
	localparam logic [3:0] ADDR_CTRL_B = 4'h2;
	localparam logic [3:0] ADDR_CTRL_C = 4'h3;
	localparam logic [3:0] ADDR_AUX_HI = 4'h4;
	localparam logic [3:0] ADDR_AUX_LO = 4'h5;
	localparam logic [3:0] ADDR_TEMP_HI = 4'h6;
	localparam logic [3:0] ADDR_TEMP_LO = 4'h7;
	localparam logic [3:0] ADDR_RES_BASE = 4'h8;
	localparam logic [3:0] ADDR_RES_LAST = 4'hd;
	localparam logic [3:0] ADDR_IDENT = 4'he;

	// reset values
	localparam logic [15:0] CTRL_A_RST = 16'h0000;
	localparam logic [15:0] CTRL_B_RST = 16'h4040;
	localparam logic [15:0] CTRL_C_RST = 16'h0000;

	// field positions, control a
	localparam int A_INT_EN = 15;
	localparam int A_CHAN_LSB = 12;
	localparam int A_MODE_LSB = 10;
	localparam int A_ACQ_LSB = 8;
	localparam int A_GAP_LSB = 0;
	// field positions, control b
	localparam int B_GPIO_EN = 13;
	localparam int B_GPIO_DATA = 12;
	localparam int B_GPIO_DIR = 11;
	localparam int B_GPIO_POL = 10;
	localparam int B_RANK_LSB = 5;
	localparam int B_SETTLE_LSB = 0;
	// field positions, control c
	localparam int C_TEMP_HI_ST = 15;
	localparam int C_TEMP_LO_ST = 14;
	localparam int C_AUX_HI_ST = 13;
	// kept clear of the channel select mask in bits 5:0
	localparam int C_AUX_LO_ST = 7;
	localparam int C_GPIO_ALERT_DIS = 12;
	localparam int C_EN_LSB = 8;
	localparam int C_SEL_LSB = 0;
	localparam int NUM_CH = 6;

	// conversion modes
	typedef enum logic [1:0] {
		TSC_MODE_OFF = 2'b00,
		TSC_MODE_SINGLE = 2'b01,
		TSC_MODE_SLAVE = 2'b10,
		TSC_MODE_MASTER = 2'b11
	} tsc_mode_t;

	// sequencer states, gray along the usual path
	typedef enum logic [2:0] {
		TSC_IDLE = 3'b000,
		TSC_SETTLE = 3'b001,
		TSC_ACQ = 3'b011,
		TSC_CONV = 3'b010,
		TSC_SORT = 3'b110,
		TSC_CLOSE = 3'b111,
		TSC_GAP = 3'b101
	} tsc_state_t;

	// times in ns and the derived cycle counts
	localparam int ACQ0_NS = 2000;
	localparam int ACQ1_NS = 4000;
	localparam int ACQ2_NS = 8000;
	localparam int ACQ3_NS = 16000;
	localparam int TEMP_ACQ_NS = 16000;
	localparam int CONV_NS = 7500;
	localparam int SORT_NS = 2000;
	localparam int SETTLE0_NS = 4000;
	localparam int SETTLE1_NS = 64000;
	localparam int SETTLE2_NS = 256000;
	localparam int SETTLE3_NS = 1024000;
	localparam int GAP_STEP_NS = 36840;
	localparam int GAP_MAX_NS = 9400000;
	localparam int ACQ0_CYC = ns_to_cyc_up(ACQ0_NS);
	localparam int ACQ1_CYC = ns_to_cyc_up(ACQ1_NS);
	localparam int ACQ2_CYC = ns_to_cyc_up(ACQ2_NS);
	localparam int ACQ3_CYC = ns_to_cyc_up(ACQ3_NS);
	localparam int TEMP_ACQ_CYC = ns_to_cyc_up(TEMP_ACQ_NS);
	localparam int CONV_CYC = ns_to_cyc_up(CONV_NS);
	localparam int SORT_CYC = ns_to_cyc_up(SORT_NS);
	localparam int SETTLE0_CYC = ns_to_cyc_up(SETTLE0_NS);
	localparam int SETTLE1_CYC = ns_to_cyc_up(SETTLE1_NS);
	// rounded down, the gap is a longest time
	localparam int GAP_STEP_CYC = GAP_STEP_NS * (MCLK_HZ / 1_000_000) / 1000;

endpackage

// ### tsc_top.sv
// touch converter control: gpio limit interrupt, sequence timing and register map
//
// How it works
// - control c bit 12 low lets gpio drive the limit interrupt, high blocks it
// - limit interrupt asserts when gpio data set, gpio is input, interrupt enabled
// - gpio only raises the interrupt in input direction
// - gpio interrupt holds until gpio pin or gpio enable bit changes
// - one settle delay precedes the first measurement of every screen channel
// - sequence without screen channels gets a single settle delay at its start
// - one closing settle delay follows the last measurement of each sequence
// - a measurement is acquisition plus conversion plus sort time
// - temperature uses a fixed 16 us acquisition, ignoring the setting
// - sort takes 2 us with rank window on, zero when off
// - each channel repeats measurement 1, 4, 8 or 16 times per window setting
// - sequence is settle per screen channel and sampling per channel, closing settle, then gap
// - gap interval is programmable from zero up to 9.4 ms
// - result registers 0x08 to 0x0d are read-only, reset zero, conversion updated
// - writable upper and lower limits for aux/battery and temperature
// - control c holds limit status, their enables, and sequence channel select
// - control b resets to 0x4040, other control and limit registers to zero
// - 0x0e reads a fixed revision and identity code
// - gpio direction bit 11: 0 output, 1 input with data following the pin
// - gpio active only when control b bit 13 is set
`timescale 1ns/1ps
module tsc_top
	import tsc_pkg::*;
#(
	parameter int SETTLE2_CYC = tsc_pkg::ns_to_cyc_up(tsc_pkg::SETTLE2_NS),
	parameter int SETTLE3_CYC = tsc_pkg::ns_to_cyc_up(tsc_pkg::SETTLE3_NS),
	parameter int GAP_STEP = tsc_pkg::GAP_STEP_CYC,
	parameter logic [15:0] PART_ID = 16'h5a01 // arbitrary value
)
(
	input wire logic mclk_i, // 25 MHz clock
	input wire logic rst_b_i, // synchronous reset, active low
	input wire logic [3:0] reg_addr_i, // register address
	input wire logic [15:0] reg_wdata_i, // write data
	input wire logic reg_wr_i, // write strobe
	input wire logic reg_rd_i, // read strobe
	output logic [15:0] reg_rdata_o, // read data, one cycle after strobe
	input wire logic [11:0] adc_data_i, // converter result, taken at end of conversion
	output logic [2:0] adc_chan_o, // analog channel address
	output logic adc_sample_o, // acquisition window
	output logic adc_convert_o, // conversion window
	output logic seq_busy_o, // sequence in progress
	input wire logic gpio_i, // gpio pin input
	output logic gpio_o, // gpio pin output
	output logic gpio_oe_o, // gpio pin output enable
	output logic limit_irq_n_o // limit interrupt, active low
);

	import tsc_pkg::*;

	if (SETTLE2_CYC < 1 || SETTLE3_CYC < 1 || GAP_STEP < 1 || GAP_STEP * 255 >= (1 << CNT_W))
	begin : g_bad_params
		$error("tsc_top: timing parameter out of range");
	end

	localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
	localparam logic [CNT_W-1:0] GAP_STEP_W = CNT_W'(GAP_STEP);

	//////////////////////////////////////////////////////////////////////////////////
	// helper functions

	// channel index order: y pos, x pos, pressure 1, pressure 2, aux/battery, temperature
	function automatic logic is_screen(input logic [2:0] idx);
		return idx < 3'd4;
	endfunction

	function automatic logic [2:0] chan_code(input logic [2:0] idx);
		case (idx)
			3'd0: return 3'b111;
			3'd1: return 3'b110;
			3'd2: return 3'b101;
			3'd3: return 3'b100;
			3'd4: return 3'b011;
			default: return 3'b001;
		endcase
	endfunction

	// maps a channel address to a result index; 010 gives 4, and 000 or 001 give 5
	function automatic logic [2:0] code_to_idx(input logic [2:0] code);
		case (code)
			3'b111: return 3'd0;
			3'b110: return 3'd1;
			3'b101: return 3'd2;
			3'b100: return 3'd3;
			3'b011: return 3'd4;
			3'b010: return 3'd4;
			default: return 3'd5;
		endcase
	endfunction

	function automatic logic [4:0] rank_samples(input logic [1:0] code);
		case (code)
			2'b00: return 5'd1;
			2'b01: return 5'd4;
			2'b10: return 5'd8;
			default: return 5'd16;
		endcase
	endfunction

	// finds the first selected channel at or after start
	function automatic logic [3:0] next_chan(input logic [5:0] mask, input logic [2:0] start);
		logic [3:0] r;
		r = 4'd8;
		for (int i = NUM_CH - 1; i >= 0; i--)
		begin
			if (mask[i] && 3'(i) >= start)
			begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	//////////////////////////////////////////////////////////////////////////////////
	// register storage

	logic [15:0] spare_q;
	logic [15:0] ctrl_a_q;
	logic [15:0] ctrl_b_q;
	logic [15:0] ctrl_c_q;
	logic [15:0] aux_hi_q;
	logic [15:0] aux_lo_q;
	logic [15:0] temp_hi_q;
	logic [15:0] temp_lo_q;
	logic [15:0] result_q [NUM_CH];
	logic [3:0] status_q;
	logic gpio_data_q;
	logic gpio_pin_q;
	logic gpio_en_q;
	logic gpio_irq_q;

	logic wr_a;
	logic [1:0] mode;
	logic gpio_en;
	logic gpio_in_dir;
	logic gpio_pol;
	logic [1:0] rank_code;
	logic [5:0] sel_mask;

	assign wr_a = reg_wr_i && reg_addr_i == ADDR_CTRL_A;
	assign mode = ctrl_a_q[A_MODE_LSB +: 2];
	assign gpio_en = ctrl_b_q[B_GPIO_EN];
	assign gpio_in_dir = ctrl_b_q[B_GPIO_DIR];
	assign gpio_pol = ctrl_b_q[B_GPIO_POL];
	assign rank_code = ctrl_b_q[B_RANK_LSB +: 2];
	assign sel_mask = ctrl_c_q[C_SEL_LSB +: NUM_CH];

	// writes to read-only locations and to 0x0f are dropped
	always_ff @(posedge mclk_i)
	begin
		if (!rst_b_i)
		begin
			spare_q <= 16'h0000;
			ctrl_a_q <= CTRL_A_RST;
			ctrl_b_q <= CTRL_B_RST;
			ctrl_c_q <= CTRL_C_RST;
			aux_hi_q <= 16'h0000;
			aux_lo_q <= 16'h0000;
			temp_hi_q <= 16'h0000;
			temp_lo_q <= 16'h0000;
		end
		else if (reg_wr_i)
		begin
			case (reg_addr_i)
				ADDR_SPARE: spare_q <= reg_wdata_i;
				ADDR_CTRL_A: ctrl_a_q <= reg_wdata_i;
				ADDR_CTRL_B: ctrl_b_q <= reg_wdata_i;
				ADDR_CTRL_C: ctrl_c_q <= reg_wdata_i;
				ADDR_AUX_HI: aux_hi_q <= reg_wdata_i;
				ADDR_AUX_LO: aux_lo_q <= reg_wdata_i;
				ADDR_TEMP_HI: temp_hi_q <= reg_wdata_i;
				ADDR_TEMP_LO: temp_lo_q <= reg_wdata_i;
				default: ;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////////////
	// gpio

	// in input direction the data bit follows the pin through the polarity
	always_ff @(posedge mclk_i)
	begin
		if (!rst_b_i)
		begin
			gpio_data_q <= CTRL_B_RST[B_GPIO_DATA];
		end
		else if (gpio_en && gpio_in_dir)
		begin
			gpio_data_q <= gpio_pol ? gpio_i : ~gpio_i;
		end
		else if (reg_wr_i && reg_addr_i == ADDR_CTRL_B)
		begin
			gpio_data_q <= reg_wdata_i[B_GPIO_DATA];
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_b_i)
		begin
			gpio_o <= 1'b0;
			gpio_oe_o <= 1'b0;
		end
		else
		begin
			gpio_o <= gpio_pol ? gpio_data_q : ~gpio_data_q;
			gpio_oe_o <= gpio_en && !gpio_in_dir;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_b_i)
		begin
			gpio_pin_q <= 1'b0;
			gpio_en_q <= 1'b0;
		end
		else
		begin
			gpio_pin_q <= gpio_i;
			gpio_en_q <= gpio_en;
		end
	end

	// a set in the same cycle as a change wins, so the request is never lost;
	// the set looks at the pin itself, since the data bit lags it by a cycle
	// and would otherwise re-arm the latch on the very change that clears it
	always_ff @(posedge mclk_i)
	begin
		if (!rst_b_i)
		begin
			gpio_irq_q <= 1'b0;
		end
		else if (gpio_en && gpio_in_dir && (gpio_pol ? gpio_i : ~gpio_i) &&
			!ctrl_c_q[C_GPIO_ALERT_DIS])
		begin
			gpio_irq_q <= 1'b1;
		end
		else if (gpio_i != gpio_pin_q || gpio_en != gpio_en_q)
		begin
			gpio_irq_q <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////
	// sequencer

	tsc_state_t state_q;
	logic [CNT_W-1:0] cnt_q;
	logic [2:0] chan_q;
	logic [4:0] samp_q;
	logic first_q;
	logic cycle_q;
	logic [5:0] run_mask_q;
	logic [3:0] nxt;
	logic [3:0] first_ch;
	logic no_screen;
	logic start;
	logic done;

	assign done = cnt_q == CNT_ONE;
	assign nxt = next_chan(run_mask_q, chan_q + 3'd1);
	assign first_ch = next_chan(sel_mask, 3'd0);
	assign no_screen = sel_mask[3:0] == 4'h0;
	assign start = wr_a && reg_wdata_i[A_MODE_LSB +: 2] != TSC_MODE_OFF;

	function automatic logic [CNT_W-1:0] settle_cyc(input logic [1:0] code);
		case (code)
			2'b00: return CNT_W'(SETTLE0_CYC);
			2'b01: return CNT_W'(SETTLE1_CYC);
			2'b10: return CNT_W'(SETTLE2_CYC);
			default: return CNT_W'(SETTLE3_CYC);
		endcase
	endfunction

	function automatic logic [CNT_W-1:0] acq_cyc(input logic [2:0] idx, input logic [1:0] code);
		if (idx == 3'd5)
		begin
			return CNT_W'(TEMP_ACQ_CYC);
		end
		case (code)
			2'b00: return CNT_W'(ACQ0_CYC);
			2'b01: return CNT_W'(ACQ1_CYC);
			2'b10: return CNT_W'(ACQ2_CYC);
			default: return CNT_W'(ACQ3_CYC);
		endcase
	endfunction

	logic [CNT_W-1:0] settle_len;
	logic [CNT_W-1:0] gap_len;
	assign settle_len = settle_cyc(ctrl_b_q[B_SETTLE_LSB +: 2]);
	assign gap_len = CNT_W'(ctrl_a_q[A_GAP_LSB +: 8]) * GAP_STEP_W;

	// one counter, loaded on entry to each phase, runs on the single clock
	always_ff @(posedge mclk_i)
	begin
		if (!rst_b_i)
		begin
			state_q <= TSC_IDLE;
			cnt_q <= CNT_ONE;
			chan_q <= 3'd0;
			samp_q <= 5'd0;
			first_q <= 1'b0;
			cycle_q <= 1'b0;
			run_mask_q <= 6'h00;
		end
		else if (wr_a && reg_wdata_i[A_MODE_LSB +: 2] == TSC_MODE_OFF)
		begin
			state_q <= TSC_IDLE;
		end
		else
		begin
			case (state_q)
				TSC_IDLE:
				begin
					if (start && reg_wdata_i[A_MODE_LSB +: 2] == TSC_MODE_SINGLE)
					begin
						run_mask_q <= 6'h01 << code_to_idx(reg_wdata_i[A_CHAN_LSB +: 3]);
						chan_q <= code_to_idx(reg_wdata_i[A_CHAN_LSB +: 3]);
						cycle_q <= 1'b0;
						state_q <= TSC_SETTLE;
						cnt_q <= settle_len;
						samp_q <= 5'd0;
					end
					else if ((start || cycle_q) && !first_ch[3])
					begin
						run_mask_q <= sel_mask;
						chan_q <= first_ch[2:0];
						first_q <= 1'b1;
						cycle_q <= 1'b0;
						samp_q <= 5'd0;
						if (is_screen(first_ch[2:0]) || no_screen)
						begin
							state_q <= TSC_SETTLE;
							cnt_q <= settle_len;
						end
						else
						begin
							state_q <= TSC_ACQ;
							cnt_q <= acq_cyc(first_ch[2:0], ctrl_a_q[A_ACQ_LSB +: 2]);
						end
					end
				end
				TSC_SETTLE:
				begin
					if (done)
					begin
						state_q <= TSC_ACQ;
						cnt_q <= acq_cyc(chan_q, ctrl_a_q[A_ACQ_LSB +: 2]);
					end
					else
					begin
						cnt_q <= cnt_q - CNT_ONE;
					end
				end
				TSC_ACQ:
				begin
					if (done)
					begin
						state_q <= TSC_CONV;
						cnt_q <= CNT_W'(CONV_CYC);
					end
					else
					begin
						cnt_q <= cnt_q - CNT_ONE;
					end
				end
				TSC_CONV, TSC_SORT:
				begin
					if (!done)
					begin
						cnt_q <= cnt_q - CNT_ONE;
					end
					else if (state_q == TSC_CONV && rank_code != 2'b00)
					begin
						state_q <= TSC_SORT;
						cnt_q <= CNT_W'(SORT_CYC);
					end
					else if (samp_q + 5'd1 < rank_samples(rank_code))
					begin
						samp_q <= samp_q + 5'd1;
						state_q <= TSC_ACQ;
						cnt_q <= acq_cyc(chan_q, ctrl_a_q[A_ACQ_LSB +: 2]);
					end
					else if (!nxt[3])
					begin
						samp_q <= 5'd0;
						first_q <= 1'b0;
						chan_q <= nxt[2:0];
						if (is_screen(nxt[2:0]))
						begin
							state_q <= TSC_SETTLE;
							cnt_q <= settle_len;
						end
						else
						begin
							state_q <= TSC_ACQ;
							cnt_q <= acq_cyc(nxt[2:0], ctrl_a_q[A_ACQ_LSB +: 2]);
						end
					end
					else
					begin
						state_q <= TSC_CLOSE;
						cnt_q <= settle_len;
					end
				end
				TSC_CLOSE:
				begin
					if (!done)
					begin
						cnt_q <= cnt_q - CNT_ONE;
					end
					else if (gap_len != 24'h000000)
					begin
						state_q <= TSC_GAP;
						cnt_q <= gap_len;
					end
					else
					begin
						state_q <= TSC_IDLE;
						cycle_q <= mode == TSC_MODE_MASTER;
					end
				end
				TSC_GAP:
				begin
					if (done)
					begin
						state_q <= TSC_IDLE;
						cycle_q <= mode == TSC_MODE_MASTER;
					end
					else
					begin
						cnt_q <= cnt_q - CNT_ONE;
					end
				end
				default: state_q <= TSC_IDLE;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////////////
	// results and limits

	logic conv_end;
	assign conv_end = state_q == TSC_CONV && done;

	// filtering is out of scope here: the last sample of the window is kept
	always_ff @(posedge mclk_i)
	begin
		if (!rst_b_i)
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				result_q[i] <= 16'h0000;
			end
		end
		else if (conv_end)
		begin
			result_q[chan_q] <= {4'h0, adc_data_i};
		end
	end

	// status bits: hardware set wins over a write-one clear in the same cycle
	logic [3:0] st_set;
	logic [3:0] st_clr;
	always_comb
	begin
		st_set = 4'h0;
		if (conv_end && chan_q == 3'd5)
		begin
			st_set[3] = {4'h0, adc_data_i} > temp_hi_q;
			st_set[2] = {4'h0, adc_data_i} < temp_lo_q;
		end
		if (conv_end && chan_q == 3'd4)
		begin
			st_set[1] = {4'h0, adc_data_i} > aux_hi_q;
			st_set[0] = {4'h0, adc_data_i} < aux_lo_q;
		end
		st_clr = 4'h0;
		if (reg_wr_i && reg_addr_i == ADDR_CTRL_C)
		begin
			st_clr = {reg_wdata_i[C_TEMP_HI_ST], reg_wdata_i[C_TEMP_LO_ST],
				reg_wdata_i[C_AUX_HI_ST], reg_wdata_i[C_AUX_LO_ST]};
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_b_i)
		begin
			status_q <= 4'h0;
		end
		else
		begin
			status_q <= st_set | (status_q & ~st_clr);
		end
	end

	//////////////////////////////////////////////////////////////////////////////////
	// outputs and read port

	logic [15:0] ctrl_b_rd;
	logic [15:0] ctrl_c_rd;
	always_comb
	begin
		ctrl_b_rd = ctrl_b_q;
		ctrl_b_rd[B_GPIO_DATA] = gpio_data_q;
		ctrl_c_rd = ctrl_c_q;
		ctrl_c_rd[C_TEMP_HI_ST] = status_q[3];
		ctrl_c_rd[C_TEMP_LO_ST] = status_q[2];
		ctrl_c_rd[C_AUX_HI_ST] = status_q[1];
		ctrl_c_rd[C_AUX_LO_ST] = status_q[0];
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_b_i)
		begin
			reg_rdata_o <= 16'h0000;
		end
		else if (reg_rd_i)
		begin
			case (reg_addr_i)
				ADDR_SPARE: reg_rdata_o <= spare_q;
				ADDR_CTRL_A: reg_rdata_o <= ctrl_a_q;
				ADDR_CTRL_B: reg_rdata_o <= ctrl_b_rd;
				ADDR_CTRL_C: reg_rdata_o <= ctrl_c_rd;
				ADDR_AUX_HI: reg_rdata_o <= aux_hi_q;
				ADDR_AUX_LO: reg_rdata_o <= aux_lo_q;
				ADDR_TEMP_HI: reg_rdata_o <= temp_hi_q;
				ADDR_TEMP_LO: reg_rdata_o <= temp_lo_q;
				ADDR_IDENT: reg_rdata_o <= PART_ID;
				default:
				begin
					if (reg_addr_i >= ADDR_RES_BASE && reg_addr_i <= ADDR_RES_LAST)
					begin
						reg_rdata_o <= result_q[3'(reg_addr_i - ADDR_RES_BASE)];
					end
					else
					begin
						reg_rdata_o <= 16'h0000;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_b_i)
		begin
			adc_chan_o <= 3'b000;
			adc_sample_o <= 1'b0;
			adc_convert_o <= 1'b0;
			seq_busy_o <= 1'b0;
			limit_irq_n_o <= 1'b1;
		end
		else
		begin
			adc_chan_o <= (state_q == TSC_IDLE) ? 3'b000 : chan_code(chan_q);
			adc_sample_o <= state_q == TSC_ACQ;
			adc_convert_o <= state_q == TSC_CONV;
			seq_busy_o <= state_q != TSC_IDLE;
			limit_irq_n_o <= !(ctrl_a_q[A_INT_EN] &&
				(gpio_irq_q || (status_q & ctrl_c_q[C_EN_LSB +: 4]) != 4'h0));
		end
	end

endmodule
